// File: hdl/pcs_pkg.sv
// package: register indices, field layouts and reset values for the control/status bank
package pcs_pkg;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 6;
    localparam int unsigned NUM_STAT = 11;

    // register indices within the bank
    localparam logic [5:0] ADDR_EXT_MON2_CFG = 6'h10;
    localparam logic [5:0] ADDR_POWER_CONTROL = 6'h11;
    localparam logic [5:0] ADDR_CLOCK_MONITOR_CONTROL = 6'h12;
    localparam logic [5:0] ADDR_STAT_BASE = 6'h13;

    // reset values
    localparam logic [7:0] RST_EXT_MON2_CFG = 8'h00;
    localparam logic [7:0] RST_POWER_CONTROL = 8'h00;
    localparam logic [7:0] RST_CLOCK_MONITOR_CONTROL = 8'h00;
    localparam logic [7:0] RST_STAT = 8'h00;
    localparam logic [7:0] RST_READ_DATA = 8'h00;

    // external monitor status field layout
    localparam int unsigned EXT_MON_STAT_IDX = 2;
    localparam int unsigned EXT_MON1_UV_BIT = 0;
    localparam int unsigned EXT_MON1_OV_BIT = 1;
    localparam int unsigned EXT_MON2_UV_BIT = 2;
    localparam int unsigned EXT_MON2_OV_BIT = 3;

    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [5:0] addr;
        logic [7:0] wdata;
    } pcs_access_type;

    typedef struct packed {
        logic diag_state;
        logic cfg_lock;
        logic ctrl_lock;
        logic ext_mon1_en;
        logic ext_mon2_en;
    } pcs_gate_type;

    typedef enum logic [1:0] {
        PCS_BUCK_OFF = 2'h0,
        PCS_BUCK_ON = 2'h1,
        PCS_BUCK_PROT = 2'h3
    } pcs_buck_state_type;
endpackage

// File: hdl/pcs_stat_reg.sv
// one clear-on-read status register with per-bit latch and conditional clear
`timescale 1ns/1ps
`default_nettype none
module pcs_stat_reg
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic [7:0] cond_in,
    input wire logic rd_in,
    output logic [7:0] flags_out
);
    logic [7:0] flags_q;
    logic [7:0] flags_d;

    // set beats clear; only flags whose condition is gone are dropped
    always_comb
    begin
        flags_d = flags_q | cond_in; // [R08]
        if (rd_in)
        begin
            flags_d = (flags_q & cond_in) | cond_in; // [R09]
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            flags_q <= pcs_pkg::RST_STAT; // [R11]
        end
        else
        begin
            flags_q <= flags_d;
        end
    end

    assign flags_out = flags_q;
endmodule
`default_nettype wire

// File: hdl/pcs_ctrl_status_regs.sv
// control registers with lock gating, clear-on-read status bank and wide-input buck enable
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// [R01] second external monitor config written only in diagnostic state with config lock clear
// [R02] power control register written only while control lock is clear
// [R03] clock monitor control register written only while control lock is clear
// [R04] power and clock monitor control reset on power-on and device reset
// [R05] wide-input buck enabled by default; no register write disables it
// [R06] buck follows wake input and wake latch in normal operation
// [R07] protection may turn buck off; it returns once restart conditions hold
// [R08] each status flag latches high until its register is read
// [R09] read clears flags whose condition is gone, keeps persisting ones
// [R10] host reads twice to confirm a flag cleared and condition gone
// [R11] status registers reset on power-on and update on each read
// [R12] external monitor voltage flags masked while that monitor is disabled
// [R13] writes to status registers change nothing
module pcs_ctrl_status_regs
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic dev_reset_in,
    input wire pcs_pkg::pcs_access_type access_in,
    input wire pcs_pkg::pcs_gate_type gate_in,
    input wire logic [87:0] stat_cond_in,
    input wire logic wake_in,
    input wire logic wake_latch_in,
    input wire logic prot_off_in,
    input wire logic restart_ok_in,
    output logic [7:0] rdata_out,
    output logic rvalid_out,
    output logic [7:0] ext_mon2_cfg_out,
    output logic [7:0] power_control_out,
    output logic [7:0] clock_monitor_control_out,
    output logic buck_en_out
);
    ////////////////////////////////////////////////////////////////////////
    logic [7:0] ext_mon2_cfg_q;
    logic [7:0] power_control_q;
    logic [7:0] clock_monitor_control_q;
    logic [7:0] rdata_q;
    logic rvalid_q;
    logic [7:0] cond [pcs_pkg::NUM_STAT];
    logic [7:0] flags [pcs_pkg::NUM_STAT];
    logic [pcs_pkg::NUM_STAT-1:0] stat_rd;
    pcs_pkg::pcs_buck_state_type buck_q;

    function automatic logic hit(input logic [5:0] a, input logic [5:0] target);
        hit = (a == target);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // control registers; status indices have no write path at all
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            ext_mon2_cfg_q <= pcs_pkg::RST_EXT_MON2_CFG;
        end
        else if (access_in.wr_en && hit(access_in.addr, pcs_pkg::ADDR_EXT_MON2_CFG)
                 && gate_in.diag_state && !gate_in.cfg_lock)
        begin
            ext_mon2_cfg_q <= access_in.wdata; // [R01]
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in || dev_reset_in)
        begin
            power_control_q <= pcs_pkg::RST_POWER_CONTROL; // [R04]
        end
        else if (access_in.wr_en && hit(access_in.addr, pcs_pkg::ADDR_POWER_CONTROL) && !gate_in.ctrl_lock)
        begin
            power_control_q <= access_in.wdata; // [R02]
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in || dev_reset_in)
        begin
            clock_monitor_control_q <= pcs_pkg::RST_CLOCK_MONITOR_CONTROL; // [R04]
        end
        else if (access_in.wr_en && hit(access_in.addr, pcs_pkg::ADDR_CLOCK_MONITOR_CONTROL)
                 && !gate_in.ctrl_lock)
        begin
            clock_monitor_control_q <= access_in.wdata; // [R03]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status bank
    genvar i;
    generate
        for (i = 0; i < pcs_pkg::NUM_STAT; i++)
        begin : g_stat
            if (i == pcs_pkg::EXT_MON_STAT_IDX)
            begin : g_ext
                always_comb
                begin
                    cond[i] = stat_cond_in[i*8 +: 8];
                    cond[i][pcs_pkg::EXT_MON1_UV_BIT] = stat_cond_in[i*8 + pcs_pkg::EXT_MON1_UV_BIT]
                                                        & gate_in.ext_mon1_en; // [R12]
                    cond[i][pcs_pkg::EXT_MON1_OV_BIT] = stat_cond_in[i*8 + pcs_pkg::EXT_MON1_OV_BIT]
                                                        & gate_in.ext_mon1_en; // [R12]
                    cond[i][pcs_pkg::EXT_MON2_UV_BIT] = stat_cond_in[i*8 + pcs_pkg::EXT_MON2_UV_BIT]
                                                        & gate_in.ext_mon2_en; // [R12]
                    cond[i][pcs_pkg::EXT_MON2_OV_BIT] = stat_cond_in[i*8 + pcs_pkg::EXT_MON2_OV_BIT]
                                                        & gate_in.ext_mon2_en; // [R12]
                end
            end
            else
            begin : g_plain
                assign cond[i] = stat_cond_in[i*8 +: 8];
            end
            // reads only; writes never reach the flags
            assign stat_rd[i] = access_in.rd_en
                                && hit(access_in.addr, pcs_pkg::ADDR_STAT_BASE + 6'(i)); // [R13]
            pcs_stat_reg u_stat
            (
                .clk_in(clk_in),
                .reset_in(reset_in),
                .cond_in(cond[i]),
                .rd_in(stat_rd[i]), // [R11]
                .flags_out(flags[i])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // read data: captured before the clear takes effect
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            rdata_q <= pcs_pkg::RST_READ_DATA;
            rvalid_q <= 1'b0;
        end
        else
        begin
            rvalid_q <= access_in.rd_en;
            if (access_in.rd_en)
            begin
                rdata_q <= pcs_pkg::RST_READ_DATA;
                if (hit(access_in.addr, pcs_pkg::ADDR_EXT_MON2_CFG))
                begin
                    rdata_q <= ext_mon2_cfg_q;
                end
                if (hit(access_in.addr, pcs_pkg::ADDR_POWER_CONTROL))
                begin
                    rdata_q <= power_control_q;
                end
                if (hit(access_in.addr, pcs_pkg::ADDR_CLOCK_MONITOR_CONTROL))
                begin
                    rdata_q <= clock_monitor_control_q;
                end
                for (int k = 0; k < pcs_pkg::NUM_STAT; k++)
                begin
                    if (stat_rd[k])
                    begin
                        rdata_q <= flags[k];
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // buck enable: no register bit feeds this, so software cannot turn it off
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            buck_q <= pcs_pkg::PCS_BUCK_ON; // [R05]
        end
        else
        begin
            unique case (buck_q)
                pcs_pkg::PCS_BUCK_ON:
                begin
                    if (prot_off_in)
                    begin
                        buck_q <= pcs_pkg::PCS_BUCK_PROT; // [R07]
                    end
                    else if (!(wake_in || wake_latch_in))
                    begin
                        buck_q <= pcs_pkg::PCS_BUCK_OFF; // [R06]
                    end
                end
                pcs_pkg::PCS_BUCK_OFF:
                begin
                    if ((wake_in || wake_latch_in) && !prot_off_in)
                    begin
                        buck_q <= pcs_pkg::PCS_BUCK_ON; // [R06]
                    end
                end
                pcs_pkg::PCS_BUCK_PROT:
                begin
                    if (restart_ok_in && !prot_off_in)
                    begin
                        buck_q <= pcs_pkg::PCS_BUCK_ON; // [R07]
                    end
                end
                default:
                begin
                    buck_q <= pcs_pkg::PCS_BUCK_PROT;
                end
            endcase
        end
    end

    assign buck_en_out = (buck_q == pcs_pkg::PCS_BUCK_ON);
    assign rdata_out = rdata_q;
    assign rvalid_out = rvalid_q;
    assign ext_mon2_cfg_out = ext_mon2_cfg_q;
    assign power_control_out = power_control_q;
    assign clock_monitor_control_out = clock_monitor_control_q;
endmodule
`default_nettype wire

// File: sim/pcs_ctrl_status_regs_sva.sv
// assertion checker for the control/status register bank
`timescale 1ns/1ps
`default_nettype none
module pcs_ctrl_status_regs_sva
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic dev_reset_in,
    input wire pcs_pkg::pcs_access_type access_in,
    input wire pcs_pkg::pcs_gate_type gate_in,
    input wire logic wake_in,
    input wire logic wake_latch_in,
    input wire logic prot_off_in,
    input wire logic restart_ok_in,
    input wire logic rvalid_out,
    input wire logic [7:0] ext_mon2_cfg_out,
    input wire logic [7:0] power_control_out,
    input wire logic [7:0] clock_monitor_control_out,
    input wire logic buck_en_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    ////////////////////////////////////////
    // device reset wins over a same-cycle write, so it is left out here
    sequence s_wr(a);
        access_in.wr_en && access_in.addr == a && !dev_reset_in;
    endsequence
    sequence s_wake;
        (wake_in || wake_latch_in) && !prot_off_in;
    endsequence
    AST_RVALID: assert property (access_in.rd_en |=> rvalid_out)
        else $error("no read answer");
    AST_PWR_WR: assert property (s_wr(pcs_pkg::ADDR_POWER_CONTROL) ##0 !gate_in.ctrl_lock
        |=> power_control_out == $past(access_in.wdata)) else $error("power write lost");
    AST_PWR_LOCK: assert property (s_wr(pcs_pkg::ADDR_POWER_CONTROL) ##0 gate_in.ctrl_lock
        |=> $stable(power_control_out)) else $error("locked power write taken");
    AST_CLK_WR: assert property (s_wr(pcs_pkg::ADDR_CLOCK_MONITOR_CONTROL) ##0 !gate_in.ctrl_lock
        |=> clock_monitor_control_out == $past(access_in.wdata)) else $error("clock write lost");
    AST_CLK_LOCK: assert property (s_wr(pcs_pkg::ADDR_CLOCK_MONITOR_CONTROL) ##0 gate_in.ctrl_lock
        |=> $stable(clock_monitor_control_out)) else $error("locked clock write taken");
    AST_CFG_WR: assert property (s_wr(pcs_pkg::ADDR_EXT_MON2_CFG)
        ##0 (gate_in.diag_state && !gate_in.cfg_lock) |=> ext_mon2_cfg_out == $past(access_in.wdata))
        else $error("open config write lost");
    AST_CFG_GATE: assert property (s_wr(pcs_pkg::ADDR_EXT_MON2_CFG)
        ##0 !(gate_in.diag_state && !gate_in.cfg_lock) |=> $stable(ext_mon2_cfg_out))
        else $error("gated config write taken");
    AST_DEVRST: assert property (dev_reset_in
        |=> power_control_out == pcs_pkg::RST_POWER_CONTROL
            && clock_monitor_control_out == pcs_pkg::RST_CLOCK_MONITOR_CONTROL)
        else $error("device reset missed");
    AST_BUCK_KEEP: assert property (buck_en_out && access_in.wr_en ##0 s_wake |=> buck_en_out)
        else $error("write turned buck off");
    AST_BUCK_PROT: assert property (buck_en_out && prot_off_in |=> !buck_en_out)
        else $error("protection ignored");
    AST_BUCK_SLEEP: assert property (buck_en_out && !wake_in && !wake_latch_in && !prot_off_in
        |=> !buck_en_out) else $error("buck stayed on");
    AST_BUCK_WAKE: assert property (!buck_en_out && restart_ok_in ##0 s_wake |=> buck_en_out)
        else $error("buck not restarted");
endmodule
////////////////////////////////////////
bind pcs_ctrl_status_regs pcs_ctrl_status_regs_sva u_sva (.clk_in, .reset_in, .dev_reset_in, .access_in,
    .gate_in, .wake_in, .wake_latch_in, .prot_off_in, .restart_ok_in, .rvalid_out, .ext_mon2_cfg_out,
    .power_control_out, .clock_monitor_control_out, .buck_en_out);
`default_nettype wire

// File: sim/pcs_host_model.sv
// host model issuing single-byte register accesses
`timescale 1ns/1ps
`default_nettype none
module pcs_host_model
(
    input wire logic clk_in,
    input wire logic rvalid_in,
    input wire logic [7:0] rdata_in,
    output var pcs_pkg::pcs_access_type acc_out
);
    initial acc_out = '0;
    // released address and data show the inverse, so stale values never match
    task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_in);
        acc_out <= {w, ~w, a, d};
        @(posedge clk_in);
        acc_out <= {2'h0, ~a, ~d};
        #1;
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask
    // answer sampled in the cycle it stands; the caller confirms a clear by a second call
    task automatic rd(input logic [5:0] a, output logic [8:0] r);
        xfer(1'b0, a, 8'h00);
        r = {rvalid_in, rdata_in};
    endtask
endmodule
`default_nettype wire

// File: sim/test_pcs_ctrl_status_regs.sv
// self-checking bench for the control/status register bank
`timescale 1ns/1ps
`default_nettype none
module test_pcs_ctrl_status_regs;
    logic clk_in, reset_in, dev_rst, wake, latch, prot, rok, rvalid, buck;
    pcs_pkg::pcs_access_type acc;
    pcs_pkg::pcs_gate_type gate;
    logic [87:0] cond;
    logic [7:0] rdata, cfg, pwr, cmon;
    logic [8:0] r;
    int fail_count, checks_done;
    pcs_ctrl_status_regs DUT (.clk_in, .reset_in, .dev_reset_in(dev_rst), .access_in(acc), .gate_in(gate),
        .stat_cond_in(cond), .wake_in(wake), .wake_latch_in(latch), .prot_off_in(prot), .restart_ok_in(rok),
        .rdata_out(rdata), .rvalid_out(rvalid), .ext_mon2_cfg_out(cfg), .power_control_out(pwr),
        .clock_monitor_control_out(cmon), .buck_en_out(buck));
    pcs_host_model host (.clk_in, .rvalid_in(rvalid), .rdata_in(rdata), .acc_out(acc));
    initial
    begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end
    ////////////////////////////////////////
    task automatic chk(input logic [8:0] g, input logic [8:0] e);
        checks_done++;
        if (g !== e)
        begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic go(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic rdc(input logic [5:0] a, input logic [7:0] e);
        host.rd(a, r);
        chk(r, {1'b1, e});
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    ////////////////////////////////////////
    task automatic t_ctrl();
        host.wr(pcs_pkg::ADDR_POWER_CONTROL, 8'h5a);
        host.wr(pcs_pkg::ADDR_CLOCK_MONITOR_CONTROL, 8'ha5);
        chk({pwr, 1'h0}, {8'h5a, 1'h0});
        chk({1'h0, cmon}, 9'h0a5);
        rdc(pcs_pkg::ADDR_POWER_CONTROL, 8'h5a);
        rdc(pcs_pkg::ADDR_CLOCK_MONITOR_CONTROL, 8'ha5);
        @(posedge clk_in) gate.ctrl_lock <= 1'h1;
        host.wr(pcs_pkg::ADDR_POWER_CONTROL, 8'h00);
        host.wr(pcs_pkg::ADDR_CLOCK_MONITOR_CONTROL, 8'h00);
        chk({1'h0, pwr}, 9'h05a);
        chk({1'h0, cmon}, 9'h0a5);
        rdc(6'h3f, pcs_pkg::RST_READ_DATA);
        @(posedge clk_in) dev_rst <= 1'h1;
        go(1);
        chk({1'h0, pwr}, {1'h0, pcs_pkg::RST_POWER_CONTROL});
        chk({1'h0, cmon}, {1'h0, pcs_pkg::RST_CLOCK_MONITOR_CONTROL});
        @(posedge clk_in) dev_rst <= 1'h0;
        gate.ctrl_lock <= 1'h0;
        $display("done ctrl");
    endtask
    task automatic t_cfg();
        logic [7:0] e;
        e = 8'h00;
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk_in) {gate.diag_state, gate.cfg_lock} <= 2'(i);
            host.wr(pcs_pkg::ADDR_EXT_MON2_CFG, 8'h10 + 8'(i));
            e = (i == 2) ? 8'h12 : e;
            chk({1'h0, cfg}, {1'h0, e});
        end
        $display("done cfg");
    endtask
    task automatic t_stat();
        logic [5:0] a;
        @(posedge clk_in) {gate.ext_mon1_en, gate.ext_mon2_en} <= 2'h3;
        for (int k = 0; k < pcs_pkg::NUM_STAT; k++)
        begin
            a = pcs_pkg::ADDR_STAT_BASE + 6'(k);
            @(posedge clk_in) cond[8*k +: 8] <= 8'h81;
            @(posedge clk_in) cond[8*k +: 8] <= 8'h01;
            host.wr(a, 8'hff);
            rdc(a, 8'h81);
            rdc(a, 8'h01);
            @(posedge clk_in) cond[8*k +: 8] <= 8'h00;
            rdc(a, 8'h01);
            rdc(a, 8'h00);
        end
        for (int j = 1; j < 3; j++)
        begin
            @(posedge clk_in) {gate.ext_mon1_en, gate.ext_mon2_en} <= 2'(j);
            @(posedge clk_in) cond[23:16] <= 8'h0f;
            @(posedge clk_in) cond[23:16] <= 8'h00;
            rdc(pcs_pkg::ADDR_STAT_BASE + 6'h02, (j == 1) ? 8'h0c : 8'h03);
        end
        $display("done stat");
    endtask
    task automatic t_buck();
        host.wr(pcs_pkg::ADDR_POWER_CONTROL, 8'hff);
        chk({8'h00, buck}, 9'h001);
        @(posedge clk_in) prot <= 1'h1;
        go(1);
        chk({8'h00, buck}, 9'h000);
        @(posedge clk_in) prot <= 1'h0;
        go(2);
        chk({8'h00, buck}, 9'h000);
        @(posedge clk_in) rok <= 1'h1;
        go(1);
        chk({8'h00, buck}, 9'h001);
        @(posedge clk_in) wake <= 1'h0;
        go(1);
        chk({8'h00, buck}, 9'h000);
        @(posedge clk_in) latch <= 1'h1;
        go(1);
        chk({8'h00, buck}, 9'h001);
        $display("done buck");
    endtask
    // mid-run power-on reset: a latched flag and a written control value must both go
    task automatic t_reset();
        @(posedge clk_in) cond[7:0] <= 8'h04;
        @(posedge clk_in) cond[7:0] <= 8'h00;
        @(posedge clk_in) reset_in <= 1'h1;
        go(2);
        chk({buck, pwr}, {1'h1, pcs_pkg::RST_POWER_CONTROL});
        @(posedge clk_in) reset_in <= 1'h0;
        go(1);
        rdc(pcs_pkg::ADDR_STAT_BASE, pcs_pkg::RST_STAT);
        $display("done reset");
    endtask
    ////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge clk_in);
        fail_count++;
        $display("[ERR] %0t run too long", $time);
        conclude();
    end
    initial
    begin
        {reset_in, dev_rst, wake, latch, prot, rok} = 6'h28;
        gate = '0;
        cond = '0;
        fail_count = 0;
        checks_done = 0;
        go(11);
        chk({rvalid, rdata}, {1'h0, pcs_pkg::RST_READ_DATA});
        chk({buck, pwr}, {1'h1, pcs_pkg::RST_POWER_CONTROL});
        chk({1'h0, cmon}, {1'h0, pcs_pkg::RST_CLOCK_MONITOR_CONTROL});
        chk({1'h0, cfg}, {1'h0, pcs_pkg::RST_EXT_MON2_CFG});
        @(posedge clk_in) reset_in <= 1'h0;
        t_ctrl();
        t_cfg();
        t_stat();
        t_buck();
        t_reset();
        conclude();
    end
endmodule
`default_nettype wire
